/* File: verilog/gpc_pkg.sv */
// Package for the general pin control block: register indices, field layout,
// reset values, function and edge-rate codes.
// Assumes an APB slave where byte address = 4 * register index.
`default_nettype none
package gpc_pkg;
  localparam int NUM_FULL  = 3;
  localparam int NUM_LOGIC = 3;
  localparam int NUM_PINS  = 6;
  localparam int ADDR_W    = 16;
  localparam int IDX_W     = 14;

  // Register indices; byte address is four times these
  localparam logic [IDX_W-1:0] IDX_SD_LEVEL   [NUM_FULL]  = '{14'h05b0, 14'h05d0, 14'h05f0};
  localparam logic [IDX_W-1:0] IDX_FULL_CFG   [NUM_FULL]  = '{14'h05b1, 14'h05d1, 14'h05f1};
  localparam logic [IDX_W-1:0] IDX_LOCK_EN    [NUM_FULL]  = '{14'h05b6, 14'h05d6, 14'h05f6};
  localparam logic [IDX_W-1:0] IDX_LOCK_STATE [NUM_FULL]  = '{14'h05ba, 14'h05da, 14'h05fa};
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR  [NUM_FULL]  = '{14'h05bc, 14'h05dc, 14'h0600};
  localparam logic [IDX_W-1:0] IDX_LOGIC_CFG  [NUM_LOGIC] = '{14'h0610, 14'h0621, 14'h0632};
  localparam logic [IDX_W-1:0] IDX_IN_LEVEL   [NUM_PINS]  = '{14'h05b4, 14'h05d4, 14'h05f4,
                                                              14'h0614, 14'h0625, 14'h0636};
  localparam logic [IDX_W-1:0] IDX_HIGH_Z     = 14'h05c1;
  localparam logic [IDX_W-1:0] IDX_EDGE_RATE  = 14'h05ca;

  // Field positions, pins 0 to 2
  localparam int FULL_SEL_LSB  = 0;
  localparam int FULL_INV_BIT  = 2;
  localparam int FULL_TYPE_BIT = 3;
  localparam int FULL_EN_BIT   = 4;
  localparam int FULL_OUT_BIT  = 5;
  localparam int FULL_CFG_W    = 6;
  // Field positions, pins 3 to 5
  localparam int LOGIC_INV_BIT  = 0;
  localparam int LOGIC_TYPE_BIT = 1;
  localparam int LOGIC_EN_BIT   = 2;
  localparam int LOGIC_OUT_BIT  = 3;
  localparam int LOGIC_CFG_W    = 4;
  // Single-bit registers sit in bit 0
  localparam int FLAG_BIT = 0;

  // Reset values
  localparam logic [7:0]             SD_LEVEL_RST  = 8'h00;
  localparam logic [FULL_CFG_W-1:0]  FULL_CFG_RST  = 6'h00;
  localparam logic [LOGIC_CFG_W-1:0] LOGIC_CFG_RST = 4'h0;
  localparam logic                   HIGH_Z_RST    = 1'b1;
  localparam logic [1:0]             EDGE_RATE_RST = 2'h0;

  typedef enum logic [1:0] {
    GPC_FUNC_SOFTWARE_OUTPUT = 2'h0,
    GPC_FUNC_INTERRUPT       = 2'h1,
    GPC_FUNC_SIGMA_DELTA     = 2'h2,
    GPC_FUNC_CLOCK           = 2'h3
  } gpc_func_t;

  typedef enum logic [1:0] {
    GPC_EDGE_FASTEST  = 2'h0,
    GPC_EDGE_SLOWEST  = 2'h1,
    GPC_EDGE_MODERATE = 2'h2,
    GPC_EDGE_FAST     = 2'h3
  } gpc_edge_t;
endpackage
`default_nettype wire

/* File: verilog/gpc_sd_if.sv */
// Carrier between the register block and a sigma-delta modulator.
// Assumes both ends share pclk.
`timescale 1ns/10ps
`default_nettype none
interface gpc_sd_if;
  logic [7:0] level;
  logic       density_bit;
  modport source    (output level, input density_bit);
  modport modulator (input level, output density_bit);
endinterface
`default_nettype wire

/* File: verilog/gpc_sigma_delta.sv */
// First-order sigma-delta modulator; density of ones is level/256.
// Assumes level comes from logic on pclk.
`timescale 1ns/10ps
`default_nettype none
module gpc_sigma_delta (
  input  wire logic pclk,
  input  wire logic presetn,
  gpc_sd_if.modulator sd
);
  logic [7:0] accum;
  logic [8:0] next_sum;

  assign next_sum = {1'b0, accum} + {1'b0, sd.level};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum          <= 8'h00;
      sd.density_bit <= 1'b0;
    end else begin
      accum          <= next_sum[7:0];
      sd.density_bit <= next_sum[8];
    end
  end
endmodule // gpc_sigma_delta
`default_nettype wire

/* File: verilog/gpc_top.sv */
// General pin control: six pins, APB register file, per-pin drive logic.
// Assumes lock_event is a one-cycle pulse on pclk; pin_in is asynchronous.
// Contract
// - Two-bit function select, reset software output
// - Eight-bit sigma-delta level, reset zero
// - Output value drives pin in software mode
// - Polarity bit inverts driven level
// - Output type: push-pull or open-drain
// - Pins 3-5 drive value when enabled
// - Lock interrupt enable per pin 0-2
// - Read-only lock interrupt state bit
// - Interrupt clear bit self-returns to zero
// - Pin 0 tristate control, resets tristate
// - Pin 0 two-bit edge rate field
// - Bit 0 reads sampled pin level
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module gpc_top #(
  parameter int CLK_DIV = 2
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic [gpc_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output var  logic [31:0]                prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  input  wire logic                       lock_event,
  input  wire logic [gpc_pkg::NUM_PINS-1:0] pin_in,
  output var  logic [gpc_pkg::NUM_PINS-1:0] pin_out,
  output var  logic [gpc_pkg::NUM_PINS-1:0] pin_oe,
  output var  logic [1:0]                 pin0_edge_rate
);
  localparam int NF = gpc_pkg::NUM_FULL;
  localparam int NL = gpc_pkg::NUM_LOGIC;
  localparam int NP = gpc_pkg::NUM_PINS;
  localparam int DIV_W = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;

  // Divider counter is at most 16 bits wide
  if (CLK_DIV < 1 || CLK_DIV > 65536) begin : g_bad_div
    $error("CLK_DIV out of range");
  end

  logic [7:0]                      sd_level   [NF];
  logic [gpc_pkg::FULL_CFG_W-1:0]  full_cfg   [NF];
  logic [gpc_pkg::LOGIC_CFG_W-1:0] logic_cfg  [NL];
  logic [NF-1:0]                   lock_irq_enable;
  logic [NF-1:0]                   lock_irq_state;
  logic                            pin_high_impedance;
  logic [NF-1:0]                   sd_bit;
  logic [NF-1:0]                   irq_clear_pulse;
  logic [NP-1:0]                   sync1;
  logic [NP-1:0]                   sync2;
  logic [NP-1:0]                   sync3;
  logic [NP-1:0]                   pin_in_level;
  logic [DIV_W-1:0]                div_count;
  logic                            clock_level;
  logic [gpc_pkg::IDX_W-1:0]       idx;
  logic                            aligned;
  logic                            setup_phase;
  logic                            write_now;
  logic [NF-1:0]                   hit_sd;
  logic [NF-1:0]                   hit_full;
  logic [NF-1:0]                   hit_len;
  logic [NF-1:0]                   hit_lst;
  logic [NF-1:0]                   hit_clr;
  logic [NL-1:0]                   hit_logic;
  logic [NP-1:0]                   hit_in;
  logic                            hit_hz;
  logic                            hit_er;
  logic                            mapped;
  logic [31:0]                     next_rdata;
  logic [NP-1:0]                   next_out;
  logic [NP-1:0]                   next_oe;

  function automatic logic idx_hit(input logic [gpc_pkg::IDX_W-1:0] a,
                                   input logic [gpc_pkg::IDX_W-1:0] b);
    return a == b;
  endfunction

  assign idx         = paddr[gpc_pkg::ADDR_W-1:2];
  assign aligned     = (paddr[1:0] == 2'h0);
  assign setup_phase = psel && !penable;
  // Writes land only at the access edge where pready is seen high
  assign write_now   = psel && penable && pready && pwrite;

  // Address decode shared by read and write paths
  always_comb begin
    hit_sd    = '0;
    hit_full  = '0;
    hit_len   = '0;
    hit_lst   = '0;
    hit_clr   = '0;
    hit_logic = '0;
    hit_in    = '0;
    for (int i = 0; i < NF; i++) begin
      hit_sd[i]   = aligned && idx_hit(idx, gpc_pkg::IDX_SD_LEVEL[i]);
      hit_full[i] = aligned && idx_hit(idx, gpc_pkg::IDX_FULL_CFG[i]);
      hit_len[i]  = aligned && idx_hit(idx, gpc_pkg::IDX_LOCK_EN[i]);
      hit_lst[i]  = aligned && idx_hit(idx, gpc_pkg::IDX_LOCK_STATE[i]);
      hit_clr[i]  = aligned && idx_hit(idx, gpc_pkg::IDX_IRQ_CLEAR[i]);
    end
    for (int i = 0; i < NL; i++) begin
      hit_logic[i] = aligned && idx_hit(idx, gpc_pkg::IDX_LOGIC_CFG[i]);
    end
    for (int i = 0; i < NP; i++) begin
      hit_in[i] = aligned && idx_hit(idx, gpc_pkg::IDX_IN_LEVEL[i]);
    end
    hit_hz = aligned && idx_hit(idx, gpc_pkg::IDX_HIGH_Z);
    hit_er = aligned && idx_hit(idx, gpc_pkg::IDX_EDGE_RATE);
    mapped = |{hit_sd, hit_full, hit_len, hit_lst, hit_clr, hit_logic, hit_in, hit_hz, hit_er};
  end

  // One wait-free access phase: answer prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !mapped;
      prdata  <= (setup_phase && !pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < NF; i++) begin
      if (hit_sd[i]) begin
        next_rdata[7:0] = sd_level[i];
      end
      if (hit_full[i]) begin
        next_rdata[gpc_pkg::FULL_CFG_W-1:0] = full_cfg[i];
      end
      if (hit_len[i]) begin
        next_rdata[gpc_pkg::FLAG_BIT] = lock_irq_enable[i];
      end
      if (hit_lst[i]) begin
        next_rdata[gpc_pkg::FLAG_BIT] = lock_irq_state[i];
      end
    end
    for (int i = 0; i < NL; i++) begin
      if (hit_logic[i]) begin
        next_rdata[gpc_pkg::LOGIC_CFG_W-1:0] = logic_cfg[i];
      end
    end
    for (int i = 0; i < NP; i++) begin
      if (hit_in[i]) begin
        next_rdata[gpc_pkg::FLAG_BIT] = pin_in_level[i];
      end
    end
    if (hit_hz) begin
      next_rdata[gpc_pkg::FLAG_BIT] = pin_high_impedance;
    end
    if (hit_er) begin
      next_rdata[1:0] = pin0_edge_rate;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NF; i++) begin
        sd_level[i] <= gpc_pkg::SD_LEVEL_RST;
        full_cfg[i] <= gpc_pkg::FULL_CFG_RST;
      end
    end else begin
      for (int i = 0; i < NF; i++) begin
        if (write_now && hit_sd[i]) begin
          sd_level[i] <= pwdata[7:0];
        end
        if (write_now && hit_full[i]) begin
          full_cfg[i] <= pwdata[gpc_pkg::FULL_CFG_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NL; i++) begin
        logic_cfg[i] <= gpc_pkg::LOGIC_CFG_RST;
      end
    end else begin
      for (int i = 0; i < NL; i++) begin
        if (write_now && hit_logic[i]) begin
          logic_cfg[i] <= pwdata[gpc_pkg::LOGIC_CFG_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_high_impedance <= gpc_pkg::HIGH_Z_RST;
      pin0_edge_rate     <= gpc_pkg::EDGE_RATE_RST;
    end else begin
      if (write_now && hit_hz) begin
        pin_high_impedance <= pwdata[gpc_pkg::FLAG_BIT];
      end
      if (write_now && hit_er) begin
        pin0_edge_rate <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_irq_enable <= '0;
    end else begin
      for (int i = 0; i < NF; i++) begin
        if (write_now && hit_len[i]) begin
          lock_irq_enable[i] <= pwdata[gpc_pkg::FLAG_BIT];
        end
      end
    end
  end

  // Clear is a pulse, never stored, reads zero
  always_comb begin
    for (int i = 0; i < NF; i++) begin
      irq_clear_pulse[i] = write_now && hit_clr[i] && pwdata[gpc_pkg::FLAG_BIT];
    end
  end

  // Sticky lock state; a new event beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_irq_state <= '0;
    end else begin
      for (int i = 0; i < NF; i++) begin
        if (lock_event && lock_irq_enable[i]) begin
          lock_irq_state[i] <= 1'b1;
        end else if (irq_clear_pulse[i]) begin
          lock_irq_state[i] <= 1'b0;
        end
      end
    end
  end

  // Three-stage sampler; only stages two and three are compared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1        <= '0;
      sync2        <= '0;
      sync3        <= '0;
      pin_in_level <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < NP; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin_in_level[i] <= sync3[i];
        end
      end
    end
  end

  // Clock function: pclk divided by 2*CLK_DIV
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count   <= '0;
      clock_level <= 1'b0;
    end else if (div_count == DIV_W'(CLK_DIV - 1)) begin
      div_count   <= '0;
      clock_level <= !clock_level;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  for (genvar g = 0; g < NF; g++) begin : g_sd
    gpc_sd_if sd_bus ();
    assign sd_bus.level = sd_level[g];
    assign sd_bit[g]    = sd_bus.density_bit;
    gpc_sigma_delta u_sd (
      .pclk    (pclk),
      .presetn (presetn),
      .sd      (sd_bus.modulator)
    );
  end

  // Drive decision per pin
  always_comb begin
    logic               level;
    logic               drive;
    gpc_pkg::gpc_func_t func;
    level = 1'b0;
    drive = 1'b0;
    func  = gpc_pkg::GPC_FUNC_SOFTWARE_OUTPUT;
    for (int i = 0; i < NP; i++) begin
      if (i < NF) begin
        func = gpc_pkg::gpc_func_t'(full_cfg[i][gpc_pkg::FULL_SEL_LSB +: 2]);
        case (func)
          gpc_pkg::GPC_FUNC_SOFTWARE_OUTPUT: level = full_cfg[i][gpc_pkg::FULL_OUT_BIT];
          gpc_pkg::GPC_FUNC_INTERRUPT:       level = lock_irq_state[i];
          gpc_pkg::GPC_FUNC_SIGMA_DELTA:     level = sd_bit[i];
          gpc_pkg::GPC_FUNC_CLOCK:           level = clock_level;
          default:                           level = 1'b0;
        endcase
        level = level ^ full_cfg[i][gpc_pkg::FULL_INV_BIT];
        drive = full_cfg[i][gpc_pkg::FULL_EN_BIT];
        if (i == 0 && pin_high_impedance) begin
          drive = 1'b0;
        end
        if (full_cfg[i][gpc_pkg::FULL_TYPE_BIT] && level) begin
          drive = 1'b0;
        end
      end else begin
        level = logic_cfg[i-NF][gpc_pkg::LOGIC_OUT_BIT] ^ logic_cfg[i-NF][gpc_pkg::LOGIC_INV_BIT];
        drive = logic_cfg[i-NF][gpc_pkg::LOGIC_EN_BIT];
        if (logic_cfg[i-NF][gpc_pkg::LOGIC_TYPE_BIT] && level) begin
          drive = 1'b0;
        end
      end
      next_out[i] = level;
      next_oe[i]  = drive;
    end
  end

  // Registered pad outputs; one cycle behind the controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end
endmodule // gpc_top
`default_nettype wire

/* File: test/gpc_props.sv */
// Checker for the pin control block: APB answers, field widths, readback.
// Assumes it is bound to gpc_top and sees only its ports on pclk.
`timescale 1ns/10ps
`default_nettype none
module gpc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [15:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  pin_in,
  input wire logic [5:0]  pin_oe,
  input wire logic [1:0]  pin0_edge_rate
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [13:0] ix;
  logic        rd, clr, sd, cfg, inh;
  logic [2:0]  k, st;
  logic [5:0]  prev;
  always_comb begin
    ix = paddr[15:2];
    rd = pready && !pwrite;
    {clr, sd, cfg, inh, k} = '0;
    for (int i = 0; i < 3; i++) begin
      clr |= ix == gpc_pkg::IDX_IRQ_CLEAR[i];
      sd |= ix == gpc_pkg::IDX_SD_LEVEL[i];
      cfg |= ix == gpc_pkg::IDX_FULL_CFG[i];
    end
    for (int i = 0; i < 6; i++) begin
      if (ix == gpc_pkg::IDX_IN_LEVEL[i]) begin
        inh = 1'b1;
        k = 3'(i);
      end
    end
  end
  // Synchroniser lag: trust readback only after the pad sat still
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= '0;
      st <= '0;
    end else begin
      prev <= pin_in;
      st <= (pin_in != prev) ? 3'd0 : (st == 3'd7) ? 3'd7 : st + 3'd1;
    end
  end
  property p_ready_setup; psel && !penable |=> pready; endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no answer after setup");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  property p_unaligned; psel && !penable && paddr[1:0] != 2'b00 |=> pslverr; endproperty
  a_unaligned: assert property (p_unaligned) else $error("unaligned access accepted");
  property p_err_zero; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error answer carries data");
  property p_idle_zero; !pready |-> prdata == 32'h0000_0000; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside access");
  property p_clear_zero; rd && clr |-> prdata == 32'h0000_0000; endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear bit reads set");
  property p_sd_width; rd && sd |-> prdata[31:8] == 24'h00_0000; endproperty
  a_sd_width: assert property (p_sd_width) else $error("level wider than a byte");
  property p_cfg_width; rd && cfg |-> prdata[31:6] == 26'h0; endproperty
  a_cfg_width: assert property (p_cfg_width) else $error("config too wide");
  property p_readback; rd && inh && st == 3'd7 |-> prdata == {31'b0, pin_in[k]}; endproperty
  a_readback: assert property (p_readback) else $error("input level mismatch");
  property p_reset_quiet; $rose(presetn) |-> pin_oe == 6'h00 && pin0_edge_rate == 2'h0; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins driven at reset");
  c_write: cover property (pready && pwrite);
  c_error: cover property (pready && pslverr);
  c_readback: cover property (rd && inh && st == 3'd7);
endmodule // gpc_props
bind gpc_top gpc_props props_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .pin_in, .pin_oe, .pin0_edge_rate);
`default_nettype wire

/* File: test/gpc_board.sv */
// Board model on the six pads: pull-ups and an optional external driver.
// Assumes the bench commands the external driver only on undriven pins.
`timescale 1ns/10ps
`default_nettype none
module gpc_board (
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] ext_en,
  input  wire logic [5:0] ext_val,
  output var  logic [5:0] pad
);
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pad[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : 1'b1;
    end
  end
endmodule // gpc_board
`default_nettype wire

/* File: test/tb_top.sv */
// Bench for the pin control block: APB register tests and pad behaviour.
// Assumes gpc_top, gpc_board and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lock_event = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, er, v, oe, p;
  logic [5:0]  pin_in, pin_out, pin_oe, ext_en = 0, ext_val = 0;
  logic [1:0]  edge_rate;
  logic [3:0]  tbl [6] = '{4'h4, 4'hc, 4'hd, 4'he, 4'h6, 4'h8};
  logic [7:0]  lv [3] = '{8'h00, 8'h40, 8'hff};
  int          err_count = 0, cmp_count = 0, ones;
  always #50 pclk = ~pclk;
  gpc_top #(.CLK_DIV(2)) dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .lock_event, .pin_in, .pin_out, .pin_oe, .pin0_edge_rate(edge_rate));
  gpc_board board_u (.pin_out, .pin_oe, .ext_en, .ext_val, .pad(pin_in));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    chk(32'(n < 16), 1);
  endtask
  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    xfer({i, 2'b00}, 1'b1, d);
  endtask
  task automatic rc(input logic [13:0] i, input logic [31:0] e);
    xfer({i, 2'b00}, 1'b0, 0);
    chk(rd, e);
  endtask
  task automatic pin_chk(input int k, input logic o, input logic l);
    repeat (2) @(posedge pclk);
    chk({31'b0, pin_oe[k]}, {31'b0, o});
    if (o) chk({31'b0, pin_out[k]}, {31'b0, l});
  endtask
  task automatic complete_run;
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rc(gpc_pkg::IDX_SD_LEVEL[i], 0);
      rc(gpc_pkg::IDX_FULL_CFG[i], 0);
      rc(gpc_pkg::IDX_LOCK_EN[i], 0);
      rc(gpc_pkg::IDX_LOCK_STATE[i], 0);
      rc(gpc_pkg::IDX_LOGIC_CFG[i], 0);
    end
    rc(gpc_pkg::IDX_HIGH_Z, 1);
    rc(gpc_pkg::IDX_EDGE_RATE, 0);
    $display("test reset done");
    wr(gpc_pkg::IDX_SD_LEVEL[1], 32'hffff_ffff);
    rc(gpc_pkg::IDX_SD_LEVEL[1], 32'h0000_00ff);
    wr(gpc_pkg::IDX_FULL_CFG[2], 32'hffff_ffc0);
    rc(gpc_pkg::IDX_FULL_CFG[2], 0);
    wr(gpc_pkg::IDX_LOCK_STATE[0], 1);
    rc(gpc_pkg::IDX_LOCK_STATE[0], 0);
    xfer(16'h16c8, 1'b0, 0);
    chk({31'b0, er}, 1);
    xfer(16'h16c6, 1'b1, 1);
    chk({31'b0, er}, 1);
    for (int c = 0; c < 4; c++) begin
      wr(gpc_pkg::IDX_EDGE_RATE, c);
      rc(gpc_pkg::IDX_EDGE_RATE, c);
      repeat (2) @(posedge pclk);
      chk({30'b0, edge_rate}, 32'(c));
    end
    $display("test registers done");
    wr(gpc_pkg::IDX_HIGH_Z, 0);
    foreach (tbl[t]) for (int k = 0; k < 6; k++) begin
      v = tbl[t][3] ^ tbl[t][0];
      oe = tbl[t][2] && !(tbl[t][1] && v);
      if (k < 3) wr(gpc_pkg::IDX_FULL_CFG[k], {26'b0, tbl[t], 2'b00});
      else wr(gpc_pkg::IDX_LOGIC_CFG[k-3], {28'b0, tbl[t]});
      pin_chk(k, oe, v);
    end
    wr(gpc_pkg::IDX_FULL_CFG[0], 32'h30);
    wr(gpc_pkg::IDX_HIGH_Z, 1);
    pin_chk(0, 1'b0, 1'b0);
    $display("test drive done");
    // Pin 2 released before its level is sampled
    wr(gpc_pkg::IDX_FULL_CFG[2], 0);
    pin_chk(2, 1'b0, 1'b0);
    for (int s = 0; s < 2; s++) begin
      ext_en <= 6'h3f;
      ext_val <= s ? 6'h15 : 6'h2a;
      repeat (10) @(posedge pclk);
      for (int k = 0; k < 6; k++) rc(gpc_pkg::IDX_IN_LEVEL[k], {31'b0, ext_val[k]});
    end
    ext_en <= 6'h00;
    $display("test readback done");
    wr(gpc_pkg::IDX_LOCK_EN[1], 1);
    wr(gpc_pkg::IDX_FULL_CFG[1], 32'h11);
    @(posedge pclk) lock_event <= 1'b1;
    @(posedge pclk) lock_event <= 1'b0;
    rc(gpc_pkg::IDX_LOCK_STATE[1], 1);
    rc(gpc_pkg::IDX_LOCK_STATE[0], 0);
    pin_chk(1, 1'b1, 1'b1);
    wr(gpc_pkg::IDX_IRQ_CLEAR[1], 1);
    rc(gpc_pkg::IDX_IRQ_CLEAR[1], 0);
    rc(gpc_pkg::IDX_LOCK_STATE[1], 0);
    pin_chk(1, 1'b1, 1'b0);
    // Event at the clearing write edge: the event wins
    fork
      wr(gpc_pkg::IDX_IRQ_CLEAR[1], 1);
      begin
        repeat (2) @(posedge pclk);
        lock_event <= 1'b1;
        @(posedge pclk) lock_event <= 1'b0;
      end
    join
    rc(gpc_pkg::IDX_LOCK_STATE[1], 1);
    pin_chk(1, 1'b1, 1'b1);
    $display("test interrupt done");
    wr(gpc_pkg::IDX_FULL_CFG[2], 32'h12);
    for (int s = 0; s < 3; s++) begin
      wr(gpc_pkg::IDX_SD_LEVEL[2], lv[s]);
      repeat (4) @(posedge pclk);
      ones = 0;
      repeat (256) begin
        @(posedge pclk);
        ones += pin_out[2];
      end
      chk(32'(ones), 32'(lv[s]));
    end
    wr(gpc_pkg::IDX_FULL_CFG[2], 32'h13);
    repeat (4) @(posedge pclk);
    p = pin_out[2];
    ones = 0;
    repeat (40) begin
      @(posedge pclk);
      ones += (pin_out[2] != p);
      p = pin_out[2];
    end
    chk(32'(ones), 20);
    $display("test modes done");
    complete_run;
  end
  // Generous span: the tests need well under 5000 cycles
  initial begin
    #(20_000 * 100);
    err_count++;
    $display("unexpected at %0t: timeout", $time);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
